// [eimc_consts.svh]
// eimc_consts.svh: offsets, field positions and timing counts of the memory controller
// assumes: included by eimc_pkg and eimc_top, definitions only
`ifndef EIMC_CONSTS_SVH
`define EIMC_CONSTS_SVH
// address phase fields on the shared address/data lines
`define EIMC_WA_LSB 2
`define EIMC_WA_MSB 21
`define EIMC_LEN_LSB 22
`define EIMC_SRC_LSB 26
`define EIMC_WR_BIT 29
// board capacities in words (128K and 256K bytes)
`define EIMC_SMALL_WORDS 21'h08000
`define EIMC_BIG_WORDS 21'h10000
// system error summary bit positions
`define EIMC_SE_CE 0
`define EIMC_SE_UE 1
`define EIMC_SE_PAR 2
`define EIMC_SE_NXM 3
// storage array cycle time
`define EIMC_CLK_NS 25
`define EIMC_CYC_NS 200
`define EIMC_CYC_CLKS ((`EIMC_CYC_NS + `EIMC_CLK_NS - 1) / `EIMC_CLK_NS)
`endif

// [eimc_pkg.sv]
// eimc_pkg: types shared by the memory controller
// assumes: eimc_consts.svh is on the include path
`include "eimc_consts.svh"
package eimc_pkg;
   typedef logic [31:0] eimc_word_t;
   typedef logic [38:0] eimc_cw_t;
   typedef enum logic [2:0] {ST_IDLE, ST_WDATA, ST_RD, ST_WR, ST_RMW, ST_RSP} eimc_state_t;
   typedef struct packed {
      eimc_state_t st;
      logic wr;
      logic [2:0] src;
      logic [19:0] wa;
      logic [1:0] b0;
      logic [3:0] bend;
      logic [2:0] nw;
      logic [2:0] iss;
      logic [2:0] got;
      logic [3:0] gap;
      logic ilv;
      logic werr;
      logic [127:0] wbuf;
      logic rsp_v;
      logic rsp_e;
      eimc_word_t rsp_d;
      logic [3:0] rsp_p;
      logic sa_start;
      logic sa_we;
      logic [15:0] sa_sel;
      logic [15:0] sa_addr;
      eimc_cw_t sa_wd;
      logic [3:0] sys_err;
      logic [2:0] log_src;
      logic [19:0] log_wa;
      logic [5:0] log_bit;
      logic [5:0] proc_fat;
      logic [5:0] proc_par;
      logic [5:0] fat1;
      logic [5:0] fat2;
   } eimc_regs_t;
endpackage

// [eimc_top.sv]
// eimc_top: central memory controller with SEC-DED, interleave and error logging
// assumes: bus and storage boards run on clk_in; fatal lines are asynchronous
//
// Functional notes
// - words stored as 32 data plus 7 check bits, generated on write
// - single-bit errors corrected on read, double-bit errors detected
// - lengths 1,2,4,6,8,10 bytes accepted, also across word boundaries
// - interleaved pairs place consecutive words on alternate boards
// - interleaved multi-word reads and full-word writes started on back-to-back cycles; merged partial words wait a board cycle
// - interleaved read words returned on consecutive bus cycles
// - boards of 128K or 256K bytes, freely mixed except within an interleaved pair
// - up to 16 boards selected from the incoming address
// - sole memory servant, central error logging
// - one parity bit per byte generated and checked on the bus
// - system error summary kept and set by hardware
// - memory error log holds requester, word address and failing bit
// - processor error register marks fatal processors and parity errors
// - all three error registers readable by software
// - requester ids cover six processor and link boards
// - address and data share lines in separate phases
// - 32 data bits with 4 byte-parity bits
`timescale 1ns/1ps
`include "eimc_consts.svh"
module eimc_top #(
   parameter int N_BRD = 16,
   parameter int N_PROC = 6
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic bus_as_in,
   input wire logic bus_dv_in,
   input wire eimc_pkg::eimc_word_t bus_ad_in,
   input wire logic [3:0] bus_par_in,
   output logic bus_busy_out,
   output logic rsp_valid_out,
   output eimc_pkg::eimc_word_t rsp_data_out,
   output logic [3:0] rsp_par_out,
   output logic rsp_err_out,
   input wire logic [N_BRD-1:0] cfg_big_in,
   input wire logic [N_BRD/2-1:0] cfg_ilv_in,
   input wire logic [N_PROC-1:0] proc_fatal_in,
   input wire logic err_clr_in,
   output logic sa_start_out,
   output logic sa_we_out,
   output logic [N_BRD-1:0] sa_sel_out,
   output logic [15:0] sa_addr_out,
   output eimc_pkg::eimc_cw_t sa_wdata_out,
   input wire eimc_pkg::eimc_cw_t sa_rdata_in,
   input wire logic sa_rvalid_in,
   output logic [3:0] sys_err_out,
   output logic [2:0] mem_err_src_out,
   output logic [19:0] mem_err_addr_out,
   output logic [5:0] mem_err_bit_out,
   output logic [2*N_PROC-1:0] proc_err_out
);
   import eimc_pkg::*;

   // ----------------------------------------
   // check code
   // ----------------------------------------
   // hamming positions 1..38, overall parity in bit 0
   function automatic eimc_cw_t ecc_enc(input eimc_word_t d);
      eimc_cw_t c;
      int k;
      c = '0;
      k = 0;
      for (int j = 1; j < 39; j++) begin
         if ((j & (j - 1)) != 0) begin
            c[j] = d[k];
            k++;
         end
      end
      for (int p = 0; p < 6; p++) begin
         for (int j = 1; j < 39; j++) begin
            if (j[p] && j != (1 << p)) c[1 << p] = c[1 << p] ^ c[j];
         end
      end
      c[0] = ^c[38:1];
      return c;
   endfunction

   // returns {double, single, syndrome, data}
   function automatic logic [39:0] ecc_dec(input eimc_cw_t cin);
      eimc_cw_t c;
      logic [5:0] syn;
      logic sb;
      logic db;
      eimc_word_t d;
      int k;
      c = cin;
      syn = '0;
      sb = 1'b0;
      db = 1'b0;
      d = '0;
      k = 0;
      for (int j = 1; j < 39; j++) begin
         if (c[j]) syn = syn ^ j[5:0];
      end
      if (^c) begin
         if (syn < 6'h27) begin
            sb = 1'b1;
            c[syn] = ~c[syn];
         end else begin
            db = 1'b1;
         end
      end else if (syn != 6'h00) begin
         db = 1'b1;
      end
      for (int j = 1; j < 39; j++) begin
         if ((j & (j - 1)) != 0) begin
            d[k] = c[j];
            k++;
         end
      end
      return {db, sb, syn, d};
   endfunction

   eimc_regs_t s_reg;
   eimc_regs_t s_next;

   // ----------------------------------------
   // board map
   // ----------------------------------------
   logic [19:0] cur_wa;
   logic [20:0] base [N_BRD:0];
   logic [N_BRD-1:0] map_sel;
   logic [15:0] loc [N_BRD-1:0];
   logic [15:0] map_loc;
   logic [N_BRD-1:0] brd_ilv;
   logic map_ilv;
   assign cur_wa = s_reg.wa + {17'h00000, s_reg.iss};
   assign base[0] = 21'h000000;
   genvar g;
   generate
      for (g = 0; g < N_BRD; g++) begin : gen_brd
         logic [20:0] sz;
         logic [20:0] lo;
         logic [20:0] span;
         logic [20:0] off;
         assign sz = cfg_big_in[g] ? `EIMC_BIG_WORDS : `EIMC_SMALL_WORDS;
         assign base[g+1] = base[g] + sz;
         assign brd_ilv[g] = cfg_ilv_in[g/2];
         assign lo = brd_ilv[g] ? base[g - g % 2] : base[g];
         assign span = brd_ilv[g] ? {sz[19:0], 1'b0} : sz;
         assign off = {1'b0, cur_wa} - lo;
         // interleaved pair: even words on even board, odd on odd
         assign map_sel[g] = ({1'b0, cur_wa} >= lo) && (off < span)
            && (!brd_ilv[g] || off[0] == 1'(g % 2));
         assign loc[g] = brd_ilv[g] ? off[16:1] : off[15:0];
      end
   endgenerate
   always_comb begin
      map_loc = '0;
      for (int i = 0; i < N_BRD; i++) begin
         if (map_sel[i]) map_loc = map_loc | loc[i];
      end
   end
   assign map_ilv = |(map_sel & brd_ilv);

   // ----------------------------------------
   // decode of bus and array words
   // ----------------------------------------
   logic par_bad;
   logic [3:0] a_len;
   logic [2:0] a_src;
   logic [3:0] a_bend;
   logic [2:0] a_nw;
   logic len_ok;
   logic rng_bad;
   logic [39:0] rd;
   logic [3:0] wmask;
   eimc_word_t wword;
   eimc_word_t mword;
   logic [19:0] err_wa;
   always_comb begin
      par_bad = 1'b0;
      for (int j = 0; j < 4; j++) begin
         if (!(^{bus_ad_in[8*j +: 8], bus_par_in[j]})) par_bad = 1'b1;
      end
   end
   assign a_len = bus_ad_in[`EIMC_LEN_LSB +: 4];
   assign a_src = bus_ad_in[`EIMC_SRC_LSB +: 3];
   assign a_bend = {2'b00, bus_ad_in[1:0]} + a_len - 4'h1;
   assign a_nw = {1'b0, a_bend[3:2]} + 3'h1;
   assign len_ok = a_len inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'ha};
   assign rng_bad = ({1'b0, bus_ad_in[`EIMC_WA_MSB:`EIMC_WA_LSB]} + {18'h0, a_nw}) > base[N_BRD];
   assign rd = ecc_dec(sa_rdata_in);
   assign wword = s_reg.wbuf[{s_reg.iss[1:0], 5'h00} +: 32];
   assign err_wa = s_reg.wa + {17'h00000, (s_reg.st == ST_RD) ? s_reg.got : s_reg.iss};
   always_comb begin
      for (int j = 0; j < 4; j++) begin
         wmask[j] = ({s_reg.iss[1:0], 2'(j)} >= {2'b00, s_reg.b0})
            && ({s_reg.iss[1:0], 2'(j)} <= s_reg.bend);
         mword[8*j +: 8] = wmask[j] ? wword[8*j +: 8] : rd[8*j +: 8];
      end
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.sa_start = 1'b0;
      s_next.sa_we = 1'b0;
      s_next.rsp_v = 1'b0;
      s_next.rsp_e = 1'b0;
      s_next.fat1 = 6'(proc_fatal_in);
      s_next.fat2 = s_reg.fat1;
      // board cycle time is kept across requests, not only inside one
      if (s_reg.gap != 4'h0) s_next.gap = s_reg.gap - 4'h1;
      // a clear in the same cycle as an event loses to the event
      if (err_clr_in) begin
         s_next.sys_err = '0;
         s_next.proc_fat = '0;
         s_next.proc_par = '0;
      end
      s_next.proc_fat = s_next.proc_fat | s_reg.fat2;
      // memory errors on a read or a merge read are logged here
      if (sa_rvalid_in && (s_reg.st == ST_RD || s_reg.st == ST_RMW) && (rd[38] || rd[39])) begin
         s_next.sys_err[rd[39] ? `EIMC_SE_UE : `EIMC_SE_CE] = 1'b1;
         s_next.log_src = s_reg.src;
         s_next.log_wa = err_wa;
         s_next.log_bit = rd[37:32];
      end
      case (s_reg.st)
         ST_IDLE: begin
            if (bus_as_in) begin
               s_next.wr = bus_ad_in[`EIMC_WR_BIT];
               s_next.src = a_src;
               s_next.wa = bus_ad_in[`EIMC_WA_MSB:`EIMC_WA_LSB];
               s_next.b0 = bus_ad_in[1:0];
               s_next.bend = a_bend;
               s_next.nw = a_nw;
               s_next.iss = '0;
               s_next.got = '0;
               s_next.werr = par_bad || !len_ok || rng_bad;
               if (par_bad) begin
                  s_next.sys_err[`EIMC_SE_PAR] = 1'b1;
                  if (a_src < 3'(N_PROC)) s_next.proc_par[a_src] = 1'b1;
               end
               if (rng_bad && len_ok) s_next.sys_err[`EIMC_SE_NXM] = 1'b1;
               if (bus_ad_in[`EIMC_WR_BIT]) s_next.st = ST_WDATA;
               else if (s_next.werr) s_next.st = ST_RSP;
               else s_next.st = ST_RD;
            end
         end
         ST_WDATA: begin
            if (bus_dv_in) begin
               s_next.wbuf[{s_reg.got[1:0], 5'h00} +: 32] = bus_ad_in;
               if (par_bad) begin
                  s_next.werr = 1'b1;
                  s_next.sys_err[`EIMC_SE_PAR] = 1'b1;
                  if (s_reg.src < 3'(N_PROC)) s_next.proc_par[s_reg.src] = 1'b1;
               end
               s_next.got = s_reg.got + 3'h1;
               if (s_reg.got + 3'h1 == s_reg.nw) s_next.st = s_next.werr ? ST_RSP : ST_WR;
            end
         end
         ST_RD: begin
            if (s_reg.iss != s_reg.nw) begin
               if (s_reg.gap != 4'h0) begin
                  s_next.gap = s_reg.gap - 4'h1;
               end else begin
                  s_next.sa_start = 1'b1;
                  s_next.sa_sel = map_sel;
                  s_next.sa_addr = map_loc;
                  s_next.iss = s_reg.iss + 3'h1;
                  s_next.ilv = map_ilv;
                  // interleaved words go out every cycle, others wait a board cycle
                  s_next.gap = map_ilv ? 4'h0 : 4'(`EIMC_CYC_CLKS - 1);
               end
            end
            if (sa_rvalid_in) begin
               s_next.rsp_v = 1'b1;
               s_next.rsp_e = rd[39];
               s_next.rsp_d = rd[39] ? 32'h00000000 : rd[31:0];
               s_next.got = s_reg.got + 3'h1;
               if (s_reg.got + 3'h1 == s_reg.nw) s_next.st = ST_IDLE;
            end
         end
         ST_WR: begin
            if (s_reg.gap != 4'h0) begin
               s_next.gap = s_reg.gap - 4'h1;
            end else begin
               s_next.sa_start = 1'b1;
               s_next.sa_sel = map_sel;
               s_next.sa_addr = map_loc;
               s_next.ilv = map_ilv;
               if (&wmask) begin
                  s_next.sa_we = 1'b1;
                  s_next.sa_wd = ecc_enc(wword);
                  s_next.iss = s_reg.iss + 3'h1;
                  s_next.gap = map_ilv ? 4'h0 : 4'(`EIMC_CYC_CLKS - 1);
                  if (s_reg.iss + 3'h1 == s_reg.nw) s_next.st = ST_RSP;
               end else begin
                  // partial word: the check bits cover the whole word, so merge first
                  s_next.st = ST_RMW;
               end
            end
         end
         ST_RMW: begin
            if (sa_rvalid_in) begin
               if (rd[39]) begin
                  s_next.werr = 1'b1;
                  s_next.st = ST_RSP;
               end else begin
                  s_next.sa_start = 1'b1;
                  s_next.sa_we = 1'b1;
                  s_next.sa_wd = ecc_enc(mword);
                  s_next.iss = s_reg.iss + 3'h1;
                  s_next.gap = 4'(`EIMC_CYC_CLKS - 1);
                  s_next.st = (s_reg.iss + 3'h1 == s_reg.nw) ? ST_RSP : ST_WR;
               end
            end
         end
         ST_RSP: begin
            s_next.rsp_v = 1'b1;
            s_next.rsp_e = s_reg.werr;
            s_next.rsp_d = 32'h00000000;
            s_next.st = ST_IDLE;
         end
         default: s_next.st = ST_IDLE;
      endcase
      for (int j = 0; j < 4; j++) s_next.rsp_p[j] = ~^s_next.rsp_d[8*j +: 8];
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) s_reg <= '0;
      else s_reg <= s_next;
   end

   assign bus_busy_out = s_reg.st != ST_IDLE;
   assign rsp_valid_out = s_reg.rsp_v;
   assign rsp_data_out = s_reg.rsp_d;
   assign rsp_par_out = s_reg.rsp_p;
   assign rsp_err_out = s_reg.rsp_e;
   assign sa_start_out = s_reg.sa_start;
   assign sa_we_out = s_reg.sa_we;
   assign sa_sel_out = s_reg.sa_sel[N_BRD-1:0];
   assign sa_addr_out = s_reg.sa_addr;
   assign sa_wdata_out = s_reg.sa_wd;
   assign sys_err_out = s_reg.sys_err;
   assign mem_err_src_out = s_reg.log_src;
   assign mem_err_addr_out = s_reg.log_wa;
   assign mem_err_bit_out = s_reg.log_bit;
   assign proc_err_out = {s_reg.proc_par[N_PROC-1:0], s_reg.proc_fat[N_PROC-1:0]};

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   logic [39:0] wchk;
   assign wchk = ecc_dec(sa_wdata_out);
   a_wr_code_clean: assert property (sa_start_out && sa_we_out |-> wchk[39:38] == 2'b00)
      else $error("written word does not decode clean");
   a_ce_returned: assert property (s_reg.st == ST_RD && sa_rvalid_in && rd[38] |=> rsp_valid_out && !rsp_err_out && rsp_data_out == $past(rd[31:0]))
      else $error("corrected word not returned");
   a_ue_flagged: assert property (s_reg.st == ST_RD && sa_rvalid_in && rd[39] |=> rsp_valid_out && rsp_err_out)
      else $error("uncorrectable word without error status");
   a_len_taken: assert property (s_reg.st == ST_IDLE && bus_as_in && !bus_ad_in[`EIMC_WR_BIT] && len_ok && !par_bad && !rng_bad |=> s_reg.st == ST_RD)
      else $error("legal read length refused");
   a_ilv_b2b: assert property (sa_start_out && !sa_we_out && s_reg.st == ST_RD && s_reg.ilv && s_reg.iss != s_reg.nw |=> sa_start_out)
      else $error("interleaved access not back to back");
   a_noilv_gap: assert property (sa_start_out && s_reg.st == ST_RD && !s_reg.ilv |=> !sa_start_out [*7])
      else $error("board cycle time violated");
   a_sel_onehot: assert property (sa_start_out |-> $onehot(sa_sel_out))
      else $error("board select not one-hot");
   a_rsp_parity: assert property (rsp_valid_out |-> (^{rsp_data_out[7:0], rsp_par_out[0]}) && (^{rsp_data_out[31:24], rsp_par_out[3]}))
      else $error("response parity wrong");
   a_log_wins: assert property (s_reg.st == ST_RD && sa_rvalid_in && rd[38] |=> sys_err_out[`EIMC_SE_CE] && mem_err_addr_out == $past(err_wa))
      else $error("corrected error not logged");
   a_fatal_mark: assert property (proc_fatal_in != '0 |-> ##3
      (proc_err_out[N_PROC-1:0] & $past(proc_fatal_in, 3)) == $past(proc_fatal_in, 3))
      else $error("fatal processor not marked");
   a_par_reply: assert property (s_reg.st == ST_IDLE && bus_as_in && par_bad && !bus_ad_in[`EIMC_WR_BIT] |-> ##2 rsp_valid_out && rsp_err_out)
      else $error("parity failure not answered with error");
endmodule

// [eimc_sa_model.sv]
// eimc_sa_model: storage array boards behind the memory controller
// assumes: eimc_top drives the array side on clk_in; reads hit written words
`timescale 1ns/1ps
module eimc_sa_model (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic sa_start_in,
   input wire logic sa_we_in,
   input wire logic [15:0] sa_sel_in,
   input wire logic [15:0] sa_addr_in,
   input wire eimc_pkg::eimc_cw_t sa_wdata_in,
   input wire logic slow_in,
   input wire eimc_pkg::eimc_cw_t flip_in,
   output eimc_pkg::eimc_cw_t sa_rdata_out,
   output logic sa_rvalid_out
);
   import eimc_pkg::*;
   // ---------------------------------------------
   // boards
   // ---------------------------------------------
   eimc_cw_t mem [int];
   eimc_cw_t dat_q [$];
   int due_q [$];
   int cyc = 0;
   int key;
   logic rv_n;
   eimc_cw_t rd_n;
   always @(posedge clk_in) begin
      cyc = cyc + 1;
      rv_n = 1'b0;
      // idle lines toggle so a stale word never passes for data
      rd_n = ~sa_rdata_out;
      if (srst_in) begin
         rd_n = '0;
         due_q.delete();
         dat_q.delete();
      end else begin
         if (sa_start_in) begin
            key = int'(sa_addr_in);
            for (int b = 0; b < 16; b++) if (sa_sel_in[b]) key = key + b * 65536;
            if (sa_we_in) mem[key] = sa_wdata_in;
            else begin
               // flip is a commanded fault: stored bits are corrupted on the way out
               due_q.push_back(cyc + (slow_in ? 7 : 3));
               dat_q.push_back((mem.exists(key) ? mem[key] : '0) ^ flip_in);
            end
         end
         if (due_q.size() > 0 && due_q[0] == cyc) begin
            void'(due_q.pop_front());
            rv_n = 1'b1;
            rd_n = dat_q.pop_front();
         end
      end
      sa_rvalid_out <= rv_n;
      sa_rdata_out <= rd_n;
   end
endmodule

// [eimc_top_tb_top.sv]
// eimc_top_tb_top: self-checking bench for the memory controller
// assumes: eimc_sa_model stands in for the boards; one 40 MHz clock
`timescale 1ns/1ps
module eimc_top_tb_top;
   import eimc_pkg::*;
   logic clk = 1'b0, srst = 1'b1, bus_as = 1'b0, bus_dv = 1'b0, clr = 1'b0, slow = 1'b0;
   eimc_word_t bus_ad = 32'h0, rsp_d;
   logic [3:0] bus_par = 4'hf, rsp_p, sys_err;
   logic [15:0] cfg_big = 16'h0, sa_sel, sa_addr;
   logic [7:0] cfg_ilv = 8'h0;
   logic [5:0] fatal = 6'h0, ebit;
   logic [2:0] esrc;
   logic [19:0] eaddr;
   logic [11:0] perr;
   logic busy, rsp_v, rsp_e, sa_start, sa_we, sa_rv;
   eimc_cw_t sa_wd, sa_rd, flip = '0;
   int fails = 0, checks = 0, cyc = 0;
   int st_cyc [$], rsp_cyc [$];
   logic [15:0] st_sel [$];
   logic [15:0] st_adr [$];
   eimc_word_t rsp_q [$];
   eimc_word_t shadow [int];
   logic rerr_q [$];
   always #12.5 clk = ~clk;
   eimc_top dut (.clk_in(clk), .srst_in(srst), .bus_as_in(bus_as), .bus_dv_in(bus_dv),
      .bus_ad_in(bus_ad), .bus_par_in(bus_par), .bus_busy_out(busy), .rsp_valid_out(rsp_v),
      .rsp_data_out(rsp_d), .rsp_par_out(rsp_p), .rsp_err_out(rsp_e), .cfg_big_in(cfg_big),
      .cfg_ilv_in(cfg_ilv), .proc_fatal_in(fatal), .err_clr_in(clr), .sa_start_out(sa_start),
      .sa_we_out(sa_we), .sa_sel_out(sa_sel), .sa_addr_out(sa_addr), .sa_wdata_out(sa_wd),
      .sa_rdata_in(sa_rd), .sa_rvalid_in(sa_rv), .sys_err_out(sys_err),
      .mem_err_src_out(esrc), .mem_err_addr_out(eaddr), .mem_err_bit_out(ebit),
      .proc_err_out(perr));
   eimc_sa_model sa (.clk_in(clk), .srst_in(srst), .sa_start_in(sa_start), .sa_we_in(sa_we),
      .sa_sel_in(sa_sel), .sa_addr_in(sa_addr), .sa_wdata_in(sa_wd), .slow_in(slow),
      .flip_in(flip), .sa_rdata_out(sa_rd), .sa_rvalid_out(sa_rv));
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic logic [3:0] par(input eimc_word_t w);
      for (int i = 0; i < 4; i++) par[i] = ~^w[8*i+:8];
   endfunction
   function automatic eimc_word_t bmask(input int k, input int off, input int len);
      for (int l = 0; l < 4; l++) bmask[8*l+:8] = (k*4+l >= off && k*4+l < off+len) ? 8'hff : 8'h0;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (sa_start === 1'b1) begin
         st_cyc.push_back(cyc);
         st_sel.push_back(sa_sel);
         st_adr.push_back(sa_addr);
      end
      if (rsp_v === 1'b1) begin
         rsp_cyc.push_back(cyc);
         rsp_q.push_back(rsp_d);
         rerr_q.push_back(rsp_e);
         check(32'(rsp_p), 32'(par(rsp_d)), "response parity");
      end
   end
   // one bus request: address phase, then back-to-back data phases for a write
   task automatic req(input logic wr, input int wa, input int off, input int len, input int src,
      input logic [3:0] pbad, input logic xe, input eimc_word_t wd [4]);
      int nw;
      int i;
      eimc_word_t m;
      eimc_word_t a;
      nw = ((off + len - 1) >> 2) + 1;
      st_cyc.delete();
      st_sel.delete();
      st_adr.delete();
      rsp_cyc.delete();
      rsp_q.delete();
      rerr_q.delete();
      a = {2'b00, wr, 3'(src), 4'(len), 20'(wa), 2'(off)};
      @(posedge clk);
      bus_as <= 1'b1;
      bus_ad <= a;
      bus_par <= par(a) ^ pbad;
      for (i = 0; i <= (wr ? nw : 0); i++) begin
         @(posedge clk);
         bus_as <= 1'b0;
         bus_dv <= wr && i < nw;
         bus_ad <= wd[i % 4];
         bus_par <= par(wd[i % 4]);
      end
      if (wr && !xe) for (i = 0; i < nw; i++) begin
         m = bmask(i, off, len);
         if (!shadow.exists(wa + i)) shadow[wa + i] = 32'h0;
         shadow[wa + i] = (shadow[wa + i] & ~m) | (wd[i] & m);
      end
      @(negedge clk);
      for (i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk);
      if (i == 400) begin
         fails++;
         $display("BAD %0t request never finished", $time);
         finish_test();
      end
      // the last response is recorded by the monitor at the next rising edge
      @(negedge clk);
      check(32'(rerr_q.size()), (wr || xe) ? 32'h1 : 32'(nw), "response count");
      for (i = 0; i < rerr_q.size(); i++) check(32'(rerr_q[i]), 32'(xe), "error status");
      if (!wr && !xe) for (i = 0; i < rsp_q.size(); i++) begin
         m = bmask(i, off, len);
         check(rsp_q[i] & m, shadow[wa + i] & m, "read data");
      end
   endtask
   task automatic clear_err(input eimc_cw_t f);
      @(posedge clk);
      clr <= 1'b1;
      flip <= f;
      @(posedge clk);
      clr <= 1'b0;
      @(negedge clk);
   endtask
   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial begin
      eimc_word_t z [4];
      int lens [6];
      int mwa [4];
      logic [15:0] mb [4], msel [4], madr [4];
      z = '{32'h0, 32'h0, 32'h0, 32'h0};
      lens = '{1, 2, 4, 6, 8, 10};
      mwa = '{32768, 72768, 98304, 32768};
      mb = '{16'h0002, 16'h0002, 16'h0002, 16'h0001};
      msel = '{16'h0002, 16'h0002, 16'h0004, 16'h0001};
      madr = '{16'h0000, 16'h9c40, 16'h0000, 16'h8000};
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      check(32'({busy, rsp_v, sa_start, sys_err, perr}), 32'h0, "reset outputs");
      req(1, 8, 0, 8, 1, 4'h0, 1'b0, '{32'h11223344, 32'h55667788, 32'h0, 32'h0});
      req(1, 10, 0, 8, 1, 4'h0, 1'b0, '{32'h99aabbcc, 32'hddeeff01, 32'h0, 32'h0});
      // offset 3 makes every length above 1 straddle words and merge partial ones
      foreach (lens[j]) begin
         req(1, 8, 3, lens[j], 2, 4'h0, 1'b0, '{32'ha5000000 + j, 32'h0f1e2d3c ^ j,
            32'h3c4b5a69 + j, 32'h7788aa00 + j});
         req(0, 8, 3, lens[j], 2, 4'h0, 1'b0, z);
      end
      req(0, 8, 0, 3, 2, 4'h0, 1'b1, z);
      $display("test lengths done");
      clear_err('0);
      req(0, 8, 0, 4, 3, 4'h1, 1'b1, z);
      check(32'(sys_err), 32'h4, "parity summary");
      check(32'(perr[11:6]), 32'h8, "requester parity flag");
      clear_err(39'h0000000020);
      check(32'({sys_err, perr}), 32'h0, "error clear");
      $display("test parity done");
      req(0, 9, 0, 4, 4, 4'h0, 1'b0, z);
      check(32'(sys_err), 32'h1, "corrected summary");
      check(32'({esrc, eaddr, ebit}), 32'({3'h4, 20'h00009, 6'h05}), "memory error log");
      clear_err(39'h0000000208);
      req(0, 9, 0, 4, 5, 4'h0, 1'b1, z);
      check(32'(sys_err), 32'h2, "uncorrectable summary");
      check(32'(esrc), 32'h5, "error requester");
      clear_err('0);
      $display("test ecc done");
      for (int j = 0; j < 4; j++) begin
         @(posedge clk);
         cfg_big <= mb[j];
         req(1, mwa[j], 0, 4, 1, 4'h0, 1'b0, z);
         check(32'(st_sel[0]), 32'(msel[j]), "board select");
         check(32'(st_adr[0]), 32'(madr[j]), "board word address");
      end
      @(posedge clk);
      cfg_big <= 16'h0;
      req(0, 524288, 0, 4, 1, 4'h0, 1'b1, z);
      check(32'(sys_err), 32'h8, "nonexistent summary");
      $display("test map done");
      @(posedge clk);
      cfg_ilv <= 8'h01;
      slow <= 1'b1;
      req(1, 0, 0, 8, 0, 4'h0, 1'b0, '{32'hcafe0001, 32'hcafe0002, 32'h0, 32'h0});
      check(32'({st_sel[0], st_sel[1]}), 32'h00010002, "pair boards");
      req(0, 0, 0, 8, 0, 4'h0, 1'b0, z);
      check(32'(st_cyc[1] - st_cyc[0]), 32'h1, "interleaved start gap");
      check(32'(rsp_cyc[1] - rsp_cyc[0]), 32'h1, "interleaved reply gap");
      @(posedge clk);
      cfg_ilv <= 8'h00;
      slow <= 1'b0;
      req(0, 8, 0, 8, 0, 4'h0, 1'b0, z);
      check(32'(st_cyc[1] - st_cyc[0]), 32'h8, "plain start gap");
      $display("test interleave done");
      @(posedge clk);
      fatal <= 6'h04;
      repeat (4) @(posedge clk);
      @(negedge clk);
      check(32'(perr[5:0]), 32'h4, "fatal processor flag");
      @(posedge clk);
      fatal <= 6'h00;
      repeat (4) @(posedge clk);
      clear_err('0);
      check(32'(perr), 32'h0, "fatal flag cleared");
      $display("test fatal done");
      finish_test();
   end
endmodule
